/* File: core/fbsc_defines.svh */
`ifndef FBSC_DEFINES_SVH
`define FBSC_DEFINES_SVH
// feature addresses
`define FBSC_FA_LOCK      8'hA0
`define FBSC_FA_CFG       8'hB0
`define FBSC_FA_STAT      8'hC0
// command codes
`define FBSC_OP_WREN      8'h06
`define FBSC_OP_RESET     8'hFF
`define FBSC_OP_SETF      8'h1F
`define FBSC_OP_GETF      8'h0F
`define FBSC_OP_PEXEC     8'h10
`define FBSC_OP_ERASE     8'hD8
`define FBSC_OP_PROTECT   8'h2C
`define FBSC_OP_PREAD     8'h13
// block lock register fields
`define FBSC_LK_WRDIS     7
`define FBSC_LK_RANGE_LSB 3
`define FBSC_LK_TOPBOT    2
`define FBSC_LK_WPHD      1
`define FBSC_LK_RESET     8'h7C
// configuration register fields
`define FBSC_CF_CFG2      7
`define FBSC_CF_CFG1      6
`define FBSC_CF_TIGHT     5
`define FBSC_CF_ECC       4
`define FBSC_CF_CFG0      1
`define FBSC_CFG_NORMAL   3'h0
`define FBSC_CFG_OTP      3'h2
`define FBSC_CFG_OTPPROT  3'h6
`define FBSC_CFG_NORRD    3'h5
`define FBSC_CFG_PERMDIS  3'h7
// status register fields
`define FBSC_ST_BUSY      0
`define FBSC_ST_EFAIL     1
`define FBSC_ST_WLATCH    2
`define FBSC_ST_PFAIL     3
// limits
`define FBSC_GROUPS       12
`define FBSC_OTP_FIRST    24'h000002
`define FBSC_OTP_LAST     24'h00000B
`define FBSC_PAGE_BITS    6
// timing
`define FBSC_CLK_MHZ      100
`define FBSC_PROG_US      300
`define FBSC_ERASE_US     2000
`define FBSC_PROG_CYCLES  (`FBSC_PROG_US * `FBSC_CLK_MHZ)
`define FBSC_ERASE_CYCLES (`FBSC_ERASE_US * `FBSC_CLK_MHZ)
`endif

/* File: core/fbsc_pkg.sv */
package fbsc_pkg;
  // one command as handed over by the serial front end
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  data;
  } fbsc_cmd_s;
  // request towards the array engine
  typedef struct packed {
    logic        valid;
    logic        erase;
    logic        otp;
    logic [23:0] row;
  } fbsc_array_s;
  // configuration probe result for the cache
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } fbsc_fill_s;
  // running busy job
  typedef enum logic [1:0] {
    JOB_IDLE    = 2'b00,
    JOB_PROG    = 2'b01,
    JOB_ERASE   = 2'b10,
    JOB_PROTECT = 2'b11
  } fbsc_job_e;
endpackage : fbsc_pkg

/* File: core/fbsc_top.sv */
// Overview of operation
// RL1: power-up locks everything, range and select ones
// RL2: reset command keeps block protection bits
// RL3: locked program or erase sets fail flag
// RL4: host unlocks by writing zero at A0h
// RL5: range code doubles per step, select end
// RL6: write-disable plus low pin freezes bits 7:2
// RL7: pin disable bit bypasses hardware protection
// RL8: write-disable and pin disable reset to zero
// RL9: lock-tight blocks range changes until power cycle; the code clears it on i_rst_n
// RL10: twelve groups, two or four blocks each
// RL11: group lock needs preceding write enable, not disabled
// RL12: group lock row bits 11:8 select group
// RL13: group lock status 0Ch on fail, 00h pass
// RL14: permanently locked groups reject program and erase
// RL15: host disables group locking via C2h sequence
// RL16: ten OTP pages, never erasable
// RL17: 50h or 40h enters OTP mode
// RL18: host uses OTP pages 02h to 0Bh, polls busy
// RL19: C0h select then execute at zero protects OTP
// RL20: config probe read returns ones or zeros
// RL21: host exits OTP with 000b then reset
// RL22: configuration field decodes five modes, readable
// RL23: pin sampled when lock write completes
`timescale 1ns/1ps
`default_nettype none
`include "fbsc_defines.svh"
module fbsc_top #(
  parameter int BLK_BITS    = 10,                  // log2 of blocks per die
  parameter int GRP_LOG2    = 2,                   // log2 of blocks per group
  parameter int PROG_CYCLES = `FBSC_PROG_CYCLES,   // program busy time in cycles
  parameter int ERASE_CYCLES = `FBSC_ERASE_CYCLES  // erase busy time in cycles
) (
  // core clock and reset
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_n,
  // write-protect pin
  input  wire logic                 i_wp_n,
  // link side, on its own clock
  input  wire logic                 i_link_clk,
  input  wire logic                 i_link_valid,
  input  wire fbsc_pkg::fbsc_cmd_s  i_link_cmd,
  output logic                      o_link_ready,
  output logic                      o_link_done,
  output logic [7:0]                o_link_rdata,
  // array engine and cache side
  output fbsc_pkg::fbsc_array_s     o_array_start,
  output fbsc_pkg::fbsc_fill_s      o_cache_fill,
  output logic                      o_otp_mode,
  output logic                      o_ecc_en
);
  localparam int CNT_W = 24;

  // ---------------- link domain ----------------
  logic               lrst_s1, lrst_s2;    // reset brought into link domain
  logic               req_tgl_l;           // flips once per accepted command
  fbsc_pkg::fbsc_cmd_s cmd_hold_l;         // stays put until the answer returns
  logic               ack_s1_l, ack_s2_l, ack_s3_l;
  logic               ack_tgl_c;           // core answer toggle, crosses to link
  logic [7:0]         rdata_c_q;           // core answer data, stable per toggle
  wire                l_take  = i_link_valid && o_link_ready;
  wire                l_ack   = ack_s2_l ^ ack_s3_l;
  wire                req_d_l = req_tgl_l ^ l_take;

  // reset synchroniser, no reset of its own
  always_ff @(posedge i_link_clk) begin
    lrst_s1 <= i_rst_n;
    lrst_s2 <= lrst_s1;
  end

  // answer toggle synchroniser
  always_ff @(posedge i_link_clk) begin
    ack_s1_l <= ack_tgl_c;
    ack_s2_l <= ack_s1_l;
    ack_s3_l <= ack_s2_l;
  end

  // command capture and answer return
  always_ff @(posedge i_link_clk) begin
    if (!lrst_s2) begin
      req_tgl_l    <= 1'b0;
      cmd_hold_l   <= '0;
      o_link_ready <= 1'b0;
      o_link_done  <= 1'b0;
      o_link_rdata <= 8'h00;
    end else begin
      req_tgl_l    <= req_d_l;
      if (l_take) begin
        cmd_hold_l <= i_link_cmd;
      end
      // one command in flight; ready only when answered
      o_link_ready <= (req_d_l == ack_s2_l);
      o_link_done  <= l_ack;
      if (l_ack) begin
        o_link_rdata <= rdata_c_q;         // held stable since the toggle
      end
    end
  end

  // ---------------- core domain ----------------
  logic                req_s1, req_s2, req_s3;
  logic                wp_s1, wp_s2;       // pin synchroniser
  logic [7:0]          lock_q;             // block lock register
  logic [2:0]          cfg_q;              // configuration select
  logic                ecc_q;
  logic                tight_q;            // lock-tight, cleared only by i_rst_n
  logic                wr_latch_q, pf_q, ef_q;
  logic                we_prev_q;          // last command was write enable
  fbsc_pkg::fbsc_job_e job_q, job_d;
  logic [CNT_W-1:0]    cnt_q;
  logic [23:0]         job_row_q;
  logic [2:0]          job_cfg_q;
  // non-volatile state: survives i_rst_n, only power-on init clears it
  logic [`FBSC_GROUPS-1:0] perm_grp_q = '0;
  logic                perm_dis_q = 1'b0;
  logic                otp_prot_q = 1'b0;
  logic                nor_rd_q   = 1'b0;

  // command decode
  wire                 req_edge = req_s2 ^ req_s3;
  wire [7:0]           op       = cmd_hold_l.op;
  wire [23:0]          row      = cmd_hold_l.addr;
  wire [7:0]           wdat     = cmd_hold_l.data;
  wire                 busy     = (job_q != fbsc_pkg::JOB_IDLE);
  wire                 take     = req_edge && !busy;   // busy drops all but feature reads
  wire                 is_we    = take && (op == `FBSC_OP_WREN);
  wire                 is_rst   = take && (op == `FBSC_OP_RESET);
  wire                 is_sf    = take && (op == `FBSC_OP_SETF);
  wire                 is_pe    = take && (op == `FBSC_OP_PEXEC) && wr_latch_q;
  wire                 is_er    = take && (op == `FBSC_OP_ERASE) && wr_latch_q;
  wire                 is_prot  = take && (op == `FBSC_OP_PROTECT) && we_prev_q
                                  && !perm_dis_q;       // RL11
  wire                 is_rd    = take && (op == `FBSC_OP_PREAD);
  wire                 sf_lock  = is_sf && (row[7:0] == `FBSC_FA_LOCK);
  wire                 sf_cfg   = is_sf && (row[7:0] == `FBSC_FA_CFG);

  // protection decode
  wire [BLK_BITS-1:0]  blk      = row[`FBSC_PAGE_BITS +: BLK_BITS];
  wire [3:0]           range_code = lock_q[`FBSC_LK_RANGE_LSB +: 4];
  wire [BLK_BITS-1:0]  grp      = blk >> GRP_LOG2;              // RL10
  wire                 perm_hit = (grp < BLK_BITS'(`FBSC_GROUPS)) &&
                                  perm_grp_q[grp[3:0]];         // RL14
  wire                 range_hit = range_locked(range_code, lock_q[`FBSC_LK_TOPBOT], blk);
  wire                 blocked  = range_hit || perm_hit;
  // pin sampled at the moment the lock write lands
  wire                 hw_frozen = lock_q[`FBSC_LK_WRDIS] && !wp_s2
                                   && !lock_q[`FBSC_LK_WPHD];   // RL6 RL7 RL23
  wire                 lock_wr_ok = !tight_q && !hw_frozen;     // RL9
  wire [2:0]           new_cfg  = {wdat[`FBSC_CF_CFG2], wdat[`FBSC_CF_CFG1],
                                   wdat[`FBSC_CF_CFG0]};
  wire                 otp_mode = (cfg_q == `FBSC_CFG_OTP);     // RL17
  wire                 otp_pg_ok = (row >= `FBSC_OTP_FIRST) && (row <= `FBSC_OTP_LAST);
  wire                 probe_cfg = (cfg_q == `FBSC_CFG_OTPPROT) ||
                                   (cfg_q == `FBSC_CFG_NORRD) ||
                                   (cfg_q == `FBSC_CFG_PERMDIS);
  wire                 done     = busy && (cnt_q == '0);
  wire [7:0]           stat     = 8'(({7'h00, busy} << `FBSC_ST_BUSY) |
                                     ({7'h00, ef_q} << `FBSC_ST_EFAIL) |
                                     ({7'h00, wr_latch_q} << `FBSC_ST_WLATCH) |
                                     ({7'h00, pf_q} << `FBSC_ST_PFAIL));
  wire [7:0]           cfg_rd   = {cfg_q[2], cfg_q[1], tight_q, ecc_q, 2'b00,
                                   cfg_q[0], 1'b0};             // RL22
  wire [7:0]           feat_rd  = (row[7:0] == `FBSC_FA_LOCK) ? lock_q :
                                  (row[7:0] == `FBSC_FA_CFG)  ? cfg_rd :
                                  (row[7:0] == `FBSC_FA_STAT) ? stat : 8'h00;
  wire                 probe_bit = (cfg_q == `FBSC_CFG_OTPPROT) ? otp_prot_q :
                                   (cfg_q == `FBSC_CFG_NORRD) ? nor_rd_q : perm_dis_q;

  // range code: 0 none, 1..10 grow by doubling, else all
  function automatic logic range_locked(input logic [3:0] code, input logic low,
                                        input logic [BLK_BITS-1:0] b);
    logic [BLK_BITS:0] total;
    logic [BLK_BITS:0] span;
    total = (BLK_BITS+1)'(1) << BLK_BITS;
    span  = total >> (4'd11 - code);
    if (code == 4'h0) begin
      range_locked = 1'b0;                                      // RL5
    end else if (code > 4'hA) begin
      range_locked = 1'b1;
    end else if (low) begin
      range_locked = ({1'b0, b} < span);
    end else begin
      range_locked = ({1'b0, b} >= (total - span));
    end
  endfunction : range_locked

  // synchronisers into the core clock
  always_ff @(posedge i_clock) begin
    req_s1 <= req_tgl_l;
    req_s2 <= req_s1;
    req_s3 <= req_s2;
    wp_s1  <= i_wp_n;
    wp_s2  <= wp_s1;
  end

  // answer to the link: feature read data, toggle for every command
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ack_tgl_c <= 1'b0;
      rdata_c_q <= 8'h00;
    end else if (req_edge) begin
      ack_tgl_c <= ~ack_tgl_c;
      rdata_c_q <= (op == `FBSC_OP_GETF) ? feat_rd : 8'h00;
    end
  end

  // feature registers
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      lock_q <= `FBSC_LK_RESET;            // RL1 RL8
      cfg_q  <= `FBSC_CFG_NORMAL;
      ecc_q  <= 1'b1;                      // ecc on by default
      tight_q <= 1'b0;
    end else if (sf_lock) begin
      // reset command never reaches this register
      if (lock_wr_ok) begin
        lock_q[7:2] <= wdat[7:2];          // RL6 RL9
      end
      lock_q[`FBSC_LK_WPHD] <= wdat[`FBSC_LK_WPHD];  // RL7
    end else if (sf_cfg) begin
      cfg_q <= new_cfg;                    // RL17 RL22
      ecc_q <= wdat[`FBSC_CF_ECC];
      tight_q <= tight_q | wdat[`FBSC_CF_TIGHT]; // RL9
    end
  end

  // status flags and job launch
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wr_latch_q <= 1'b0;
      pf_q      <= 1'b0;
      ef_q      <= 1'b0;
      we_prev_q <= 1'b0;
      job_row_q <= 24'h000000;
      job_cfg_q <= `FBSC_CFG_NORMAL;
    end else begin
      if (take) begin
        we_prev_q <= is_we;                // strict adjacency
      end
      if (is_we) begin
        wr_latch_q <= 1'b1;
      end else if (is_rst) begin
        wr_latch_q <= 1'b0;                // RL2 keeps lock_q intact
        pf_q  <= 1'b0;
        ef_q  <= 1'b0;
      end else if (is_pe) begin
        job_row_q <= row;
        job_cfg_q <= cfg_q;
        // refused program flags right away, no busy phase
        pf_q <= (job_d == fbsc_pkg::JOB_IDLE);                  // RL3
      end else if (is_er) begin
        ef_q <= (job_d == fbsc_pkg::JOB_IDLE);                  // RL3 RL16
      end else if (is_prot) begin
        job_row_q <= row;
        pf_q      <= 1'b0;
        ef_q      <= 1'b0;                 // stale erase fail would spoil 0Ch
      end else if (done) begin
        unique case (job_q)
          fbsc_pkg::JOB_PROTECT: begin
            // invalid group keeps the enable latch and sets fail: 0Ch, else 00h
            if (job_row_q[11:8] > 4'hB) begin
              pf_q <= 1'b1;                                     // RL12 RL13
            end else begin
              wr_latch_q <= 1'b0;                               // RL13
              ef_q       <= 1'b0;
            end
          end
          fbsc_pkg::JOB_PROG, fbsc_pkg::JOB_ERASE: begin
            wr_latch_q <= 1'b0;
          end
          fbsc_pkg::JOB_IDLE: begin
            wr_latch_q <= wr_latch_q;
          end
        endcase
      end
    end
  end

  // which job a command starts
  always_comb begin
    job_d = job_q;
    if (done) begin
      job_d = fbsc_pkg::JOB_IDLE;
    end else if (is_prot) begin
      job_d = fbsc_pkg::JOB_PROTECT;
    end else if (is_er && !otp_mode && !blocked) begin
      job_d = fbsc_pkg::JOB_ERASE;
    end else if (is_pe) begin
      if (cfg_q == `FBSC_CFG_NORMAL && !blocked) begin
        job_d = fbsc_pkg::JOB_PROG;                             // RL3
      end else if (otp_mode && otp_pg_ok && !otp_prot_q) begin
        job_d = fbsc_pkg::JOB_PROG;                             // RL16 RL17
      end else if (probe_cfg && row == 24'h000000) begin
        job_d = fbsc_pkg::JOB_PROG;                             // RL19
      end
    end
  end

  // busy counter
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      job_q <= fbsc_pkg::JOB_IDLE;
      cnt_q <= '0;
    end else begin
      job_q <= job_d;
      if (!busy && job_d == fbsc_pkg::JOB_ERASE) begin
        cnt_q <= CNT_W'(ERASE_CYCLES - 1);
      end else if (!busy && job_d != fbsc_pkg::JOB_IDLE) begin
        cnt_q <= CNT_W'(PROG_CYCLES - 1);
      end else if (busy) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // non-volatile bits, set at job end only, never cleared
  always_ff @(posedge i_clock) begin
    if (done && job_q == fbsc_pkg::JOB_PROTECT && job_row_q[11:8] <= 4'hB) begin
      perm_grp_q[job_row_q[11:8]] <= 1'b1;                      // RL14
    end
    if (done && job_q == fbsc_pkg::JOB_PROG) begin
      if (job_cfg_q == `FBSC_CFG_OTPPROT) otp_prot_q <= 1'b1;   // RL19
      if (job_cfg_q == `FBSC_CFG_PERMDIS) perm_dis_q <= 1'b1;   // RL11
      if (job_cfg_q == `FBSC_CFG_NORRD)   nor_rd_q   <= 1'b1;
    end
  end

  // outputs towards array and cache
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_array_start <= '0;
      o_cache_fill  <= '0;
      o_otp_mode    <= 1'b0;
      o_ecc_en      <= 1'b1;
    end else begin
      o_array_start.valid <= !busy && (job_d == fbsc_pkg::JOB_PROG ||
                                       job_d == fbsc_pkg::JOB_ERASE) && !probe_cfg;
      o_array_start.erase <= (job_d == fbsc_pkg::JOB_ERASE);
      o_array_start.otp   <= otp_mode;
      o_array_start.row   <= row;
      o_cache_fill.valid  <= is_rd && probe_cfg && (row == 24'h000000);   // RL20
      o_cache_fill.value  <= probe_bit ? 8'h00 : 8'hFF;                   // RL20
      o_otp_mode          <= otp_mode;
      o_ecc_en            <= ecc_q;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_powerup_lock;
    !i_rst_n ##1 i_rst_n |-> lock_q == 8'h7C;
  endproperty
  a_powerup_lock: assert property (disable iff (1'b0) p_powerup_lock) // RL1
    else $error("lock register not fully locked after reset");

  property p_reset_keeps;
    is_rst |=> lock_q == $past(lock_q);
  endproperty
  a_reset_keeps: assert property (p_reset_keeps) // RL2
    else $error("reset command changed block protection");

  property p_refuse_flag;
    is_pe && cfg_q == 3'h0 && blocked |=> pf_q && !busy;
  endproperty
  a_refuse_flag: assert property (p_refuse_flag) // RL3
    else $error("locked program not refused");

  property p_frozen;
    sf_lock && hw_frozen |=> lock_q[7:2] == $past(lock_q[7:2]);
  endproperty
  a_frozen: assert property (p_frozen) // RL6
    else $error("frozen lock bits changed");

  property p_lot_sticky;
    tight_q |=> tight_q && (!$past(sf_lock) || lock_q[7:2] == $past(lock_q[7:2]));
  endproperty
  a_lot_sticky: assert property (p_lot_sticky) // RL9
    else $error("lock-tight lost or bypassed");

  property p_prot_needs_we;
    take && op == 8'h2C && !we_prev_q |=> job_q == fbsc_pkg::JOB_IDLE;
  endproperty
  a_prot_needs_we: assert property (p_prot_needs_we) // RL11
    else $error("group lock without write enable");

  sequence s_prot_start;
    is_prot && row[11:8] > 4'hB;
  endsequence
  property p_prot_fail;
    s_prot_start |=> job_q == fbsc_pkg::JOB_PROTECT && wr_latch_q && !pf_q;
  endproperty
  a_prot_fail: assert property (p_prot_fail) // RL12
    else $error("invalid group lock not run as a busy job");
  property p_prot_status;
    done && job_q == fbsc_pkg::JOB_PROTECT |=> stat == (job_row_q[11:8] > 4'hB ?
                                                         8'h0C : 8'h00);
  endproperty
  a_prot_status: assert property (p_prot_status) // RL13
    else $error("group lock status value wrong");

  property p_perm_sticky;
    (perm_grp_q & $past(perm_grp_q)) == $past(perm_grp_q);
  endproperty
  a_perm_sticky: assert property (p_perm_sticky) // RL14
    else $error("permanent group lock cleared");

  property p_probe_fill;
    is_rd && probe_cfg && row == 24'h0 |=>
      o_cache_fill.valid && o_cache_fill.value == ($past(probe_bit) ? 8'h00 : 8'hFF);
  endproperty
  a_probe_fill: assert property (p_probe_fill) // RL20
    else $error("configuration probe value wrong");

  property p_otp_no_erase;
    is_er && otp_mode |=> ef_q && job_q == fbsc_pkg::JOB_IDLE;
  endproperty
  a_otp_no_erase: assert property (p_otp_no_erase) // RL16
    else $error("erase accepted in OTP mode");
endmodule : fbsc_top
`default_nettype wire

/* File: dv/fbsc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fbsc_host (
  // link clock
  input  wire logic            i_link_clk,
  // command offer
  output logic                 o_valid,
  output fbsc_pkg::fbsc_cmd_s  o_cmd,
  // device answer
  input  wire logic            i_ready,
  input  wire logic            i_done,
  input  wire logic [7:0]      i_rdata
);
  // idle until the bench asks for a command
  initial begin
    o_valid = 1'b0;
    o_cmd   = '0;
  end
  // one command at a time: offer on ready, hold to the taking edge
  task automatic issue(input logic [7:0] op, input logic [23:0] a,
                       input logic [7:0] d, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge i_link_clk);
    while (i_ready !== 1'b1 && n < 100) begin
      @(posedge i_link_clk);
      n++;
    end
    o_valid <= 1'b1;
    o_cmd   <= {op, a, d};
    @(posedge i_link_clk);
    // released bus shows inverted bits, not the stale command
    o_valid <= 1'b0;
    o_cmd   <= ~o_cmd;
    rd = 'x;
    n  = 0;
    while (n < 40) begin
      @(posedge i_link_clk);
      n++;
      if (i_done === 1'b1) begin
        rd = i_rdata;
        n  = 99;
      end
    end
  endtask : issue
endmodule : fbsc_host
`default_nettype wire

/* File: dv/fbsc_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fbsc_top_tb;
  // short busy times keep the run brief
  localparam int PC = 20;
  localparam int EC = 40;
  logic                  clock, link_clk, rst_n, wp_n, link_valid, link_ready, link_done;
  logic                  otp_mode, ecc_en, last_otp, last_erase;
  logic [7:0]            link_rdata, rd, last_fill;
  logic [23:0]           last_row;
  fbsc_pkg::fbsc_cmd_s   link_cmd;
  fbsc_pkg::fbsc_array_s array_start;
  fbsc_pkg::fbsc_fill_s  cache_fill;
  int                    error_cnt, comparisons, starts, fills;
  fbsc_top #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) i_dut (
    .i_clock(clock), .i_rst_n(rst_n), .i_wp_n(wp_n), .i_link_clk(link_clk),
    .i_link_valid(link_valid), .i_link_cmd(link_cmd), .o_link_ready(link_ready),
    .o_link_done(link_done), .o_link_rdata(link_rdata), .o_array_start(array_start),
    .o_cache_fill(cache_fill), .o_otp_mode(otp_mode), .o_ecc_en(ecc_en));
  fbsc_host i_host (.i_link_clk(link_clk), .o_valid(link_valid), .o_cmd(link_cmd),
    .i_ready(link_ready), .i_done(link_done), .i_rdata(link_rdata));
  // core clock, 10 ns
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // link clock, 15 ns, offset phase
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  // catch one-cycle core pulses
  always @(posedge clock) begin
    if (array_start.valid === 1'b1) begin
      starts++;
      last_otp = array_start.otp;
      last_erase = array_start.erase;
      last_row = array_start.row;
    end
    if (cache_fill.valid === 1'b1) begin
      fills++;
      last_fill = cache_fill.value;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
    i_host.issue(op, a, d, rd);
    // an answer that never came counts as a mismatch
    if ($isunknown(rd)) error_cnt++;
  endtask : cmd
  task automatic getf(input logic [7:0] fa, input logic [7:0] exp);
    cmd(8'h0F, {16'h0000, fa}, 8'h00);
    check(rd, exp);
  endtask : getf
  // poll status until not busy, bounded
  task automatic wait_idle();
    int n;
    n  = 0;
    rd = 8'h01;
    while (rd[0] !== 1'b0 && n < 200) begin
      cmd(8'h0F, 24'h0000C0, 8'h00);
      n++;
    end
  endtask : wait_idle
  // write enable, operation, masked status, then clear flags
  task automatic job(input logic [7:0] op, input logic [23:0] row,
                     input logic [7:0] st, input logic [7:0] m);
    int s0;
    s0 = starts;
    cmd(8'h06, 24'h0, 8'h00);
    cmd(op, row, 8'h00);
    wait_idle();
    check(rd & m, st);
    if (m == 8'hFF && op != 8'h2C) check(8'(starts - s0), {7'h0, st == 8'h00});
    cmd(8'hFF, 24'h0, 8'h00);
  endtask : job
  task automatic probe(input logic [7:0] d, input logic [7:0] exp);
    int f0;
    f0 = fills;
    cmd(8'h1F, 24'h0000B0, d);
    cmd(8'h13, 24'h0, 8'h00);
    wait_idle();
    check(8'(fills - f0), 8'h01);
    check(last_fill, exp);
  endtask : probe
  task automatic t_reset();
    check({7'h0, ecc_en}, 8'h01);
    getf(8'hA0, 8'h7C);
    getf(8'hB0, 8'h10);
    getf(8'hC0, 8'h00);
    job(8'h10, 24'h000040, 8'h0C, 8'hFF);
    job(8'hD8, 24'h000040, 8'h02, 8'h02);
    cmd(8'h1F, 24'h0000A0, 8'h08);
    cmd(8'hFF, 24'h0, 8'h00);
    getf(8'hA0, 8'h08);
  endtask : t_reset
  // range codes 1 to 11, both ends, at the boundary block
  task automatic t_range();
    int k;
    int b;
    for (k = 1; k <= 11; k++) begin
      b = (k > 10) ? 0 : 1024 - (1 << (k - 1));
      cmd(8'h1F, 24'h0000A0, 8'(k << 3));
      job(8'h10, 24'(b << 6), 8'h0C, 8'hFF);
      if (k <= 10) job(8'h10, 24'((b - 1) << 6), 8'h00, 8'hFF);
      b = (k > 10) ? 1023 : (1 << (k - 1)) - 1;
      cmd(8'h1F, 24'h0000A0, 8'((k << 3) | 4));
      job(8'h10, 24'(b << 6), 8'h0C, 8'hFF);
      if (k <= 10) job(8'h10, 24'((b + 1) << 6), 8'h00, 8'hFF);
    end
    cmd(8'h1F, 24'h0000A0, 8'h00);
    getf(8'hA0, 8'h00);
  endtask : t_range
  task automatic t_pin();
    @(posedge clock) wp_n <= 1'b0;
    repeat (4) @(posedge clock);
    cmd(8'h1F, 24'h0000A0, 8'h80);
    cmd(8'h1F, 24'h0000A0, 8'h08);
    getf(8'hA0, 8'h80);
    cmd(8'h1F, 24'h0000A0, 8'h02);
    getf(8'hA0, 8'h82);
    cmd(8'h1F, 24'h0000A0, 8'h80);
    @(posedge clock) wp_n <= 1'b1;
    repeat (4) @(posedge clock);
    cmd(8'h1F, 24'h0000A0, 8'h00);
    getf(8'hA0, 8'h00);
  endtask : t_pin
  task automatic t_group();
    job(8'h2C, 24'h000300, 8'h00, 8'hFF);
    job(8'h10, 24'(13 << 6), 8'h0C, 8'hFF);
    job(8'h10, 24'(16 << 6), 8'h00, 8'hFF);
    job(8'h10, 24'(11 << 6), 8'h00, 8'hFF);
    job(8'hD8, 24'(16 << 6), 8'h00, 8'hFF);
    check({7'h0, last_erase}, 8'h01);
    check(last_row[13:6], 8'h10);
    job(8'hD8, 24'(13 << 6), 8'h02, 8'h02);
    job(8'h2C, 24'h000C00, 8'h0C, 8'hFF);
    cmd(8'h06, 24'h0, 8'h00);
    cmd(8'h0F, 24'h0000C0, 8'h00);
    cmd(8'h2C, 24'h000400, 8'h00);
    wait_idle();
    check(rd, 8'h04);
    cmd(8'hFF, 24'h0, 8'h00);
    job(8'h10, 24'(17 << 6), 8'h00, 8'hFF);
  endtask : t_group
  task automatic t_otp();
    cmd(8'h1F, 24'h0000B0, 8'h50);
    getf(8'hB0, 8'h50);
    check({7'h0, otp_mode}, 8'h01);
    job(8'h10, 24'h000002, 8'h00, 8'hFF);
    check({7'h0, last_otp}, 8'h01);
    job(8'hD8, 24'h000040, 8'h02, 8'h02);
    cmd(8'h1F, 24'h0000B0, 8'h40);
    check({7'h0, ecc_en}, 8'h00);
    probe(8'h82, 8'hFF);
    getf(8'hB0, 8'h82);
    probe(8'hC2, 8'hFF);
    job(8'h10, 24'h0, 8'h00, 8'h7F);
    probe(8'hC2, 8'h00);
    probe(8'hC0, 8'hFF);
    job(8'h10, 24'h0, 8'h00, 8'h7F);
    probe(8'hC0, 8'h00);
    cmd(8'h1F, 24'h0000B0, 8'h40);
    job(8'h10, 24'h000003, 8'h0C, 8'hFF);
    cmd(8'h1F, 24'h0000B0, 8'h00);
    cmd(8'hFF, 24'h0, 8'h00);
    check({7'h0, otp_mode}, 8'h00);
    job(8'h10, 24'(20 << 6), 8'h00, 8'hFF);
    check({7'h0, last_otp}, 8'h00);
    cmd(8'h06, 24'h0, 8'h00);
    cmd(8'h2C, 24'h000500, 8'h00);
    wait_idle();
    check(rd, 8'h04);
  endtask : t_otp
  task automatic t_tight();
    cmd(8'h1F, 24'h0000B0, 8'h30);
    cmd(8'h1F, 24'h0000A0, 8'h7C);
    cmd(8'hFF, 24'h0, 8'h00);
    cmd(8'h1F, 24'h0000B0, 8'h10);
    getf(8'hA0, 8'h00);
    getf(8'hB0, 8'h30);
    @(posedge clock) rst_n <= 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    getf(8'hB0, 8'h10);
    cmd(8'h1F, 24'h0000A0, 8'h00);
    job(8'h10, 24'(13 << 6), 8'h0C, 8'hFF);
  endtask : t_tight
  task automatic final_report();
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    starts = 0;
    fills = 0;
    last_fill = 8'h00;
    last_otp = 1'b0;
    last_erase = 1'b0;
    last_row = 24'h000000;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_range();
    t_pin();
    t_group();
    t_otp();
    t_tight();
    final_report();
  end
  // watchdog, far beyond the expected run
  initial begin
    #900000;
    error_cnt++;
    final_report();
  end
endmodule : fbsc_top_tb
`default_nettype wire
